/* File: rtcap_checker.sv */
// port assertions for the reload timer
`timescale 1ns/1ns

module rtcap_checker
(
  input wire logic       REF_CLK,
  input wire logic       RST,
  input wire logic       RUN_CONTROL,
  input wire logic       SPLIT_MODE_SELECT,
  input wire logic       CAPTURE_MODE_ENABLE,
  input wire logic       TIMER_IRQ_ENABLE,
  input wire logic       LOW_OVERFLOW_IRQ_ENABLE,
  input wire logic       HIGH_FLAG_CLR,
  input wire logic       LOW_FLAG_CLR,
  input wire logic       COUNT_LOW_WR,
  input wire logic       COUNT_HIGH_WR,
  input wire logic       RELOAD_LOW_WR,
  input wire logic       RELOAD_HIGH_WR,
  input wire logic [7:0] COUNT_LOW,
  input wire logic [7:0] COUNT_HIGH,
  input wire logic [7:0] RELOAD_LOW,
  input wire logic [7:0] RELOAD_HIGH,
  input wire logic       HIGH_OVERFLOW_FLAG,
  input wire logic       LOW_OVERFLOW_FLAG,
  input wire logic       TIMER_IRQ
);
  logic [15:0] cnt;
  logic        nowr;
  logic        m16;
  assign cnt  = {COUNT_HIGH, COUNT_LOW};
  assign nowr = !COUNT_LOW_WR && !COUNT_HIGH_WR;
  assign m16  = !SPLIT_MODE_SELECT && !CAPTURE_MODE_ENABLE;

  default clocking @(posedge REF_CLK); endclocking
  default disable iff (RST);

  sequence s_wrap16;
    m16 && nowr && cnt == 16'hffff ##1 cnt != 16'hffff;
  endsequence
  sequence s_wrap_low;
    SPLIT_MODE_SELECT && !CAPTURE_MODE_ENABLE && !COUNT_LOW_WR &&
    COUNT_LOW == 8'hff ##1 COUNT_LOW != 8'hff;
  endsequence

  property p_wrap16;
    s_wrap16 |-> cnt == {$past(RELOAD_HIGH), $past(RELOAD_LOW)} &&
      HIGH_OVERFLOW_FLAG && LOW_OVERFLOW_FLAG;
  endproperty
  a_wrap16: assert property (p_wrap16)
    else $error("16-bit wrap did not reload");
  property p_irq;
    TIMER_IRQ == ($past(TIMER_IRQ_ENABLE) && (HIGH_OVERFLOW_FLAG ||
      $past(LOW_OVERFLOW_IRQ_ENABLE) && LOW_OVERFLOW_FLAG));
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt level wrong");
  property p_hsticky;
    HIGH_OVERFLOW_FLAG && !HIGH_FLAG_CLR |=> HIGH_OVERFLOW_FLAG;
  endproperty
  a_hsticky: assert property (p_hsticky)
    else $error("high flag dropped");
  property p_lsticky;
    LOW_OVERFLOW_FLAG && !LOW_FLAG_CLR |=> LOW_OVERFLOW_FLAG;
  endproperty
  a_lsticky: assert property (p_lsticky)
    else $error("low flag dropped");
  property p_split_low;
    s_wrap_low |-> COUNT_LOW == $past(RELOAD_LOW) && LOW_OVERFLOW_FLAG;
  endproperty
  a_split_low: assert property (p_split_low)
    else $error("split low byte did not reload");
  property p_split_run;
    SPLIT_MODE_SELECT && !CAPTURE_MODE_ENABLE && !RUN_CONTROL &&
      !COUNT_HIGH_WR |=> $stable(COUNT_HIGH);
  endproperty
  a_split_run: assert property (p_split_run)
    else $error("stopped high byte moved");
  property p_run16;
    m16 && !RUN_CONTROL && nowr |=> $stable(cnt);
  endproperty
  a_run16: assert property (p_run16)
    else $error("stopped 16-bit counter moved");
  property p_capture;
    CAPTURE_MODE_ENABLE && !RELOAD_LOW_WR && !RELOAD_HIGH_WR |=>
      $stable({RELOAD_HIGH, RELOAD_LOW}) || HIGH_OVERFLOW_FLAG &&
      {RELOAD_HIGH, RELOAD_LOW} == $past(cnt);
  endproperty
  a_capture: assert property (p_capture)
    else $error("capture value or flag wrong");
  property p_free;
    CAPTURE_MODE_ENABLE && nowr && cnt == 16'hffff |=>
      cnt == 16'hffff || cnt == 16'h0000;
  endproperty
  a_free: assert property (p_free)
    else $error("capture counter reloaded");
endmodule // rtcap_checker

bind rtcap_top rtcap_checker u_chk (.*);

/* File: rtcap_src.sv */
// package and count-source conditioning for the reload timer
package rtcap_pkg;

  // ----------------------------------------
  // timing and field constants
  // ----------------------------------------
  localparam int unsigned SYS_DIV         = 12;
  localparam logic [1:0]  XSEL_EXT_DIV8   = 2'h1;
  localparam logic [1:0]  XSEL_COMPARATOR = 2'h3;
  localparam int unsigned XSEL_CAP_BIT    = 1;
  localparam logic [7:0]  BYTE_MAX        = 8'hff;
  localparam logic [7:0]  BYTE_ZERO       = 8'h00;
  localparam logic [7:0]  COUNT_RST       = 8'h00;
  localparam logic [7:0]  RELOAD_RST      = 8'h00;

  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef struct packed {
    logic sys_div12;
    logic ext_div8;
    logic cmp_rise;
  } rtcap_ticks_t;

endpackage

`timescale 1ns/1ns

module rtcap_src
(
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire logic                  ext_div8_pin,
  input  wire logic                  comparator_pin,
  output rtcap_pkg::rtcap_ticks_t    ticks
);

  // ----------------------------------------
  // two-stage synchronisers
  // ----------------------------------------
  logic [1:0] ext_meta_reg;
  logic [1:0] cmp_meta_reg;
  logic       ext_last_reg;
  logic       cmp_last_reg;
  logic [3:0] div_reg;
  logic       div_tick_reg;

  // R8: synchronise sources
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ext_meta_reg <= 2'h0;
      cmp_meta_reg <= 2'h0;
      ext_last_reg <= 1'b0;
      cmp_last_reg <= 1'b0;
    end
    else
    begin
      ext_meta_reg <= {ext_meta_reg[0], ext_div8_pin};
      cmp_meta_reg <= {cmp_meta_reg[0], comparator_pin};
      ext_last_reg <= ext_meta_reg[1];
      cmp_last_reg <= cmp_meta_reg[1];
    end
  end

  // ----------------------------------------
  // system clock prescaler
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      div_reg      <= 4'h0;
      div_tick_reg <= 1'b0;
    end
    else if (div_reg == 4'(rtcap_pkg::SYS_DIV - 1))
    begin
      div_reg      <= 4'h0;
      div_tick_reg <= 1'b1;
    end
    else
    begin
      div_reg      <= div_reg + 4'h1;
      div_tick_reg <= 1'b0;
    end
  end

  // R17: one-cycle rising edges
  assign ticks = '{sys_div12: div_tick_reg,
                   ext_div8:  ext_meta_reg[1] & ~ext_last_reg,
                   cmp_rise:  cmp_meta_reg[1] & ~cmp_last_reg};

endmodule // rtcap_src

/* File: rtcap_top.sv */
// reload timer with split and capture modes
//
// How it works
// R1: split select 0 gives one 16-bit timer, 1 gives two bytes
// R2: 16-bit wrap loads reload value and sets the high flag
// R3: timer irq enable interrupts on each full 16-bit overflow
// R4: with low irq enable too, low byte wraps also interrupt
// R5: split bytes count apart, each reloading from its own byte
// R6: in split mode run control gates only the high byte
// R7: clock select 1 gives system clock, else external select field
// R8: divided external clock and comparator are synchronised first
// R9: split mode sets high flag on high wrap, low on low
// R10: split irq on high wraps, on either with low irq enable
// R11: flags are only cleared by software, which checks both
// R12: software keeps split select zero while capturing
// R13: capture on comparator rise or every eight external clocks
// R14: capture copies count into reload and sets the high flag
// R15: capture source bit 0 picks comparator, 1 external clock
// R16: in capture mode the counter runs free without reloading
// R17: comparator rises found by comparing with previous sample
// R18: high flag is set when the high byte wraps to zero
// R19: low flag is set on every low byte wrap, any mode
`timescale 1ns/1ns

module rtcap_top
(
  input  wire logic       REF_CLK,
  input  wire logic       RST,
  input  wire logic       RUN_CONTROL,
  input  wire logic       SPLIT_MODE_SELECT,
  input  wire logic       CAPTURE_MODE_ENABLE,
  input  wire logic [1:0] EXTERNAL_CLOCK_SELECT,
  input  wire logic       HIGH_BYTE_CLOCK_SELECT,
  input  wire logic       LOW_BYTE_CLOCK_SELECT,
  input  wire logic       TIMER_IRQ_ENABLE,
  input  wire logic       LOW_OVERFLOW_IRQ_ENABLE,
  input  wire logic       HIGH_FLAG_CLR,
  input  wire logic       LOW_FLAG_CLR,
  input  wire logic       COUNT_LOW_WR,
  input  wire logic       COUNT_HIGH_WR,
  input  wire logic       RELOAD_LOW_WR,
  input  wire logic       RELOAD_HIGH_WR,
  input  wire logic [7:0] WR_DATA,
  input  wire logic       EXT_CLK_DIV8,
  input  wire logic       COMPARATOR_OUT,
  output logic      [7:0] COUNT_LOW,
  output logic      [7:0] COUNT_HIGH,
  output logic      [7:0] RELOAD_LOW,
  output logic      [7:0] RELOAD_HIGH,
  output logic            HIGH_OVERFLOW_FLAG,
  output logic            LOW_OVERFLOW_FLAG,
  output logic            TIMER_IRQ
);

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  rtcap_pkg::rtcap_ticks_t ticks;

  logic [7:0] count_low_reg;
  logic [7:0] count_high_reg;
  logic [7:0] reload_low_reg;
  logic [7:0] reload_high_reg;
  logic       high_flag_reg;
  logic       low_flag_reg;
  logic       irq_reg;

  logic [7:0] count_low_next;
  logic [7:0] count_high_next;
  logic [7:0] reload_low_next;
  logic [7:0] reload_high_next;
  logic       high_flag_next;
  logic       low_flag_next;
  logic       irq_next;

  logic       split;
  logic       low_tick;
  logic       high_tick;
  logic       low_inc;
  logic       high_inc;
  logic       low_wrap;
  logic       high_wrap;
  logic       capture_evt;

  // R7: count source selection
  function automatic logic pick_tick
  (
    input logic                    msel,
    input logic [1:0]              xsel,
    input rtcap_pkg::rtcap_ticks_t t
  );
    logic sel;
    sel = t.sys_div12;
    if (msel)
      sel = 1'b1;
    else if (xsel == rtcap_pkg::XSEL_EXT_DIV8)
      sel = t.ext_div8;
    else if (xsel == rtcap_pkg::XSEL_COMPARATOR)
      sel = t.cmp_rise;
    return sel;
  endfunction

  // ----------------------------------------
  // source conditioning
  // ----------------------------------------
  rtcap_src u_src
  (
    .clk            (REF_CLK),
    .rst            (RST),
    .ext_div8_pin   (EXT_CLK_DIV8),
    .comparator_pin (COMPARATOR_OUT),
    .ticks          (ticks)
  );

  // ----------------------------------------
  // counting decisions
  // ----------------------------------------
  always_comb
  begin
    low_tick  = pick_tick(LOW_BYTE_CLOCK_SELECT, EXTERNAL_CLOCK_SELECT,
                          ticks);
    high_tick = pick_tick(HIGH_BYTE_CLOCK_SELECT, EXTERNAL_CLOCK_SELECT,
                          ticks);
    // R1: mode from split select
    // R12: capture forces the full 16-bit counter
    split = SPLIT_MODE_SELECT & ~CAPTURE_MODE_ENABLE;
    if (split)
    begin
      // R6: low byte free, high byte gated
      low_inc  = low_tick;
      high_inc = high_tick & RUN_CONTROL;
    end
    else
    begin
      low_inc  = low_tick & RUN_CONTROL;
      high_inc = low_inc & (count_low_reg == rtcap_pkg::BYTE_MAX);
    end
    low_wrap  = low_inc & (count_low_reg == rtcap_pkg::BYTE_MAX);
    high_wrap = high_inc & (count_high_reg == rtcap_pkg::BYTE_MAX);
    // R13: capture event source
    // R15: source bit picks the event
    if (EXTERNAL_CLOCK_SELECT[rtcap_pkg::XSEL_CAP_BIT])
      capture_evt = CAPTURE_MODE_ENABLE & ticks.ext_div8;
    else
      capture_evt = CAPTURE_MODE_ENABLE & ticks.cmp_rise;
  end

  // ----------------------------------------
  // counter next values
  // ----------------------------------------
  always_comb
  begin
    count_low_next  = count_low_reg;
    count_high_next = count_high_reg;
    if (low_inc)
      count_low_next = count_low_reg + 8'h01;
    if (high_inc)
      count_high_next = count_high_reg + 8'h01;
    // R16: capture mode wraps without reload
    if (!CAPTURE_MODE_ENABLE)
    begin
      if (split)
      begin
        // R5: each byte reloads from its own byte
        if (low_wrap)
          count_low_next = reload_low_reg;
        if (high_wrap)
          count_high_next = reload_high_reg;
      end
      else if (high_wrap)
      begin
        // R2: full wrap loads 16-bit reload
        count_low_next  = reload_low_reg;
        count_high_next = reload_high_reg;
      end
    end
    if (COUNT_LOW_WR)
      count_low_next = WR_DATA;
    if (COUNT_HIGH_WR)
      count_high_next = WR_DATA;
  end

  // ----------------------------------------
  // reload next values
  // ----------------------------------------
  always_comb
  begin
    reload_low_next  = reload_low_reg;
    reload_high_next = reload_high_reg;
    if (RELOAD_LOW_WR)
      reload_low_next = WR_DATA;
    if (RELOAD_HIGH_WR)
      reload_high_next = WR_DATA;
    // R14: capture copies count to reload
    if (capture_evt)
    begin
      reload_low_next  = count_low_reg;
      reload_high_next = count_high_reg;
    end
  end

  // ----------------------------------------
  // flags and interrupt
  // ----------------------------------------
  always_comb
  begin
    // R11: only software clears, set wins
    high_flag_next = high_flag_reg & ~HIGH_FLAG_CLR;
    low_flag_next  = low_flag_reg & ~LOW_FLAG_CLR;
    // R9: high wrap sets high flag
    // R18: high flag on high byte wrap
    // R14: capture sets high flag
    if (high_wrap | capture_evt)
      high_flag_next = 1'b1;
    // R19: low flag on any low wrap
    if (low_wrap)
      low_flag_next = 1'b1;
    // R3: full overflow interrupt
    // R4: low wraps interrupt with low enable
    // R10: either byte with low enable
    irq_next = TIMER_IRQ_ENABLE &
               (high_flag_next | (LOW_OVERFLOW_IRQ_ENABLE & low_flag_next));
  end

  // ----------------------------------------
  // state registers
  // ----------------------------------------
  always_ff @(posedge REF_CLK)
  begin
    if (RST)
    begin
      count_low_reg  <= rtcap_pkg::COUNT_RST;
      count_high_reg <= rtcap_pkg::COUNT_RST;
    end
    else
    begin
      count_low_reg  <= count_low_next;
      count_high_reg <= count_high_next;
    end
  end

  always_ff @(posedge REF_CLK)
  begin
    if (RST)
    begin
      reload_low_reg  <= rtcap_pkg::RELOAD_RST;
      reload_high_reg <= rtcap_pkg::RELOAD_RST;
    end
    else
    begin
      reload_low_reg  <= reload_low_next;
      reload_high_reg <= reload_high_next;
    end
  end

  always_ff @(posedge REF_CLK)
  begin
    if (RST)
    begin
      high_flag_reg <= 1'b0;
      low_flag_reg  <= 1'b0;
      irq_reg       <= 1'b0;
    end
    else
    begin
      high_flag_reg <= high_flag_next;
      low_flag_reg  <= low_flag_next;
      irq_reg       <= irq_next;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign COUNT_LOW          = count_low_reg;
  assign COUNT_HIGH         = count_high_reg;
  assign RELOAD_LOW         = reload_low_reg;
  assign RELOAD_HIGH        = reload_high_reg;
  assign HIGH_OVERFLOW_FLAG = high_flag_reg;
  assign LOW_OVERFLOW_FLAG  = low_flag_reg;
  assign TIMER_IRQ          = irq_reg;

endmodule // rtcap_top

/* File: tb.sv */
// self-checking bench for the reload timer
`timescale 1ns/1ns

module tb;
  logic       clk, rst, run, split, cap, hsel, lsel, tie, lie;
  logic       hclr, lclr, clw, chw, rlw, rhw, ext, cmp;
  logic [1:0] xsel, pgen;
  logic [3:0] ph;
  logic [7:0] wd, cl, ch, rl, rh, hb;
  logic       hf, lf, irq;
  int         miscompares, num_checks;

  rtcap_top uut
  (
    .REF_CLK(clk), .RST(rst), .RUN_CONTROL(run),
    .SPLIT_MODE_SELECT(split), .CAPTURE_MODE_ENABLE(cap),
    .EXTERNAL_CLOCK_SELECT(xsel), .HIGH_BYTE_CLOCK_SELECT(hsel),
    .LOW_BYTE_CLOCK_SELECT(lsel), .TIMER_IRQ_ENABLE(tie),
    .LOW_OVERFLOW_IRQ_ENABLE(lie), .HIGH_FLAG_CLR(hclr),
    .LOW_FLAG_CLR(lclr), .COUNT_LOW_WR(clw), .COUNT_HIGH_WR(chw),
    .RELOAD_LOW_WR(rlw), .RELOAD_HIGH_WR(rhw), .WR_DATA(wd),
    .EXT_CLK_DIV8(ext), .COMPARATOR_OUT(cmp), .COUNT_LOW(cl),
    .COUNT_HIGH(ch), .RELOAD_LOW(rl), .RELOAD_HIGH(rh),
    .HIGH_OVERFLOW_FLAG(hf), .LOW_OVERFLOW_FLAG(lf), .TIMER_IRQ(irq)
  );

  always #20 clk = ~clk;

  // ext pin period 16 cycles, comparator 8, so sources differ
  always @(posedge clk)
  begin
    ph  <= ph + 4'h1;
    ext <= pgen[0] & ph[3];
    cmp <= pgen[1] & ph[2];
  end

  task report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task chk(input logic [15:0] g, input logic [15:0] e);
    num_checks++;
    if (g !== e)
    begin
      miscompares++;
      $display("wrong value at %0t: got %h exp %h", $time, g, e);
    end
  endtask

  task chkf(input logic [2:0] e);
    chk({13'h0000, hf, lf, irq}, {13'h0000, e});
  endtask

  // k: 0 count low, 1 count high, 2 reload low, 3 reload high
  task wr(input logic [1:0] k, input logic [7:0] d);
    @(posedge clk) {rhw, rlw, chw, clw} <= 4'h1 << k;
    wd <= d;
    @(posedge clk) {rhw, rlw, chw, clw} <= 4'h0;
  endtask

  task step;
    @(posedge clk) run <= 1'b1;
    @(posedge clk) run <= 1'b0;
    #1;
  endtask

  task lstep;
    @(posedge clk) lsel <= 1'b1;
    @(posedge clk) lsel <= 1'b0;
    #1;
  endtask

  task clr;
    @(posedge clk) {hclr, lclr} <= 2'h3;
    @(posedge clk) {hclr, lclr} <= 2'h0;
    #1 chkf(3'h0);
  endtask

  function logic [15:0] obs(input logic s);
    return s ? {rh, rl} : {8'h00, cl};
  endfunction

  // cycles between two changes; capture also checks value spacing
  task per(input logic s, input logic [15:0] e);
    int          n;
    logic [15:0] v, u;
    u = obs(s);
    n = 0;
    repeat (2)
    begin
      v = u;
      n = 0;
      while (obs(s) === v && n < 100)
      begin
        @(posedge clk);
        #1 n++;
      end
      u = obs(s);
    end
    chk(n[15:0], e);
    if (s)
      chk(u - v, e);
  endtask

  initial
  begin
    {clk, run, split, cap, lie, hclr, lclr, clw, chw, rlw, rhw} = '0;
    {xsel, pgen, wd, ph, ext, cmp} = '0;
    {rst, lsel, hsel, tie} = 4'hf;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    #1 chk({ch, cl}, 16'h0000);
    chk({rh, rl}, 16'h0000);
    chkf(3'h0);
    wr(2, 8'h34);
    wr(3, 8'h12);
    wr(0, 8'hff);
    wr(1, 8'hff);
    step;
    chk({ch, cl}, 16'h1234);
    chkf(3'h7);
    repeat (5) @(posedge clk);
    #1 chkf(3'h7);
    clr;
    @(posedge clk) lie <= 1'b1;
    wr(1, 8'h00);
    wr(0, 8'hff);
    step;
    chk({ch, cl}, 16'h0100);
    chkf(3'h3);
    clr;
    @(posedge clk) lie <= 1'b0;
    wr(0, 8'hff);
    step;
    chkf(3'h2);
    clr;
    @(posedge clk)
    begin
      split <= 1'b1;
      lsel  <= 1'b0;
      xsel  <= 2'h1;
    end
    wr(2, 8'h80);
    wr(3, 8'h40);
    wr(0, 8'hff);
    wr(1, 8'hff);
    lstep;
    chk({ch, cl}, 16'hff80);
    chkf(3'h2);
    step;
    chk({ch, cl}, 16'h4080);
    chkf(3'h7);
    clr;
    @(posedge clk) pgen <= 2'h3;
    for (int i = 0; i < 4; i++)
    begin
      @(posedge clk) xsel <= i[1:0];
      per(1'b0, i[0] ? (i[1] ? 16'h0008 : 16'h0010) : 16'h000c);
    end
    @(posedge clk)
    begin
      hsel <= 1'b0;
      run  <= 1'b1;
    end
    #1 hb = ch;
    repeat (16) @(posedge clk);
    #1 chk({8'h00, 8'(ch - hb)}, 16'h0002);
    @(posedge clk)
    begin
      split <= 1'b0;
      cap   <= 1'b1;
      lsel  <= 1'b1;
      run   <= 1'b1;
      xsel  <= 2'h0;
    end
    wr(0, 8'hf0);
    wr(1, 8'hff);
    per(1'b1, 16'h0008);
    chk({15'h0000, hf}, 16'h0001);
    @(posedge clk) xsel <= 2'h2;
    per(1'b1, 16'h0010);
    report_and_stop;
  end

  initial
  begin
    #400000;
    miscompares++;
    report_and_stop;
  end
endmodule // tb
